// ===== design/mpc_loader.sv
// multi-mode pin configuration loader with host override and power good
`timescale 1ns/100ps
// How it works
// R1: sample pins at power-up and Restore
// R2: classify pin low, open, high, resistor
// R3: one strap pin three, two nine
// R4: resistor mode gives 25 codes per pin
// R5: address and ceiling only from pins
// R6: ceiling is pin voltage plus ten percent
// R7: host may overwrite and read settings
// R8: store active configuration in persistent memory
// R9: regulate from pin settings without programming
// R10: host-set threshold raises alert toward host
// R11: power good 100 ms after in band
// R12: outside drives enable high to run
// R13: latched settings hold until next sampling
module mpc_loader
  import mpc_pkg::*;
#(
  parameter int         GOOD_CYCLES = GOOD_DELAY_CYCLES, // power good delay
  parameter logic [6:0] ADDR_BASE   = 7'h20              // first bus address
)(
  input  wire logic               clk,                    // 100 MHz clock
  input  wire logic               rst_n,                  // power-on reset, low
  input  mpc_pkg::mpc_raw_s       pin_raw [PIN_COUNT],    // multi-mode pins, async
  input  wire logic               enable_pin,             // enable input, async
  input  wire logic               in_band_pin,            // output in band, async
  input  wire logic               restore_cmd,            // Restore command pulse
  input  wire logic               host_wr_valid,          // host write strobe
  input  wire logic [1:0]         host_wr_sel,            // setting selector
  input  wire logic [9:0]         host_wr_data,           // write value
  input  wire logic               host_rd_valid,          // host read strobe
  input  wire logic [1:0]         host_rd_sel,            // setting selector
  input  wire logic               host_store,             // store to persistent memory
  input  wire logic               host_alert_clear,       // clear the alert
  input  wire logic               store_valid,            // store holds an image
  input  mpc_pkg::mpc_store_s     store_rd_data,          // image read at power-up
  input  wire logic [9:0]         vout_meas,              // measured output, 10 mV
  output logic [10:0]             host_rd_data,           // read value
  output logic                    host_rd_ack,            // read answer pulse
  output logic                    store_wr_en,            // store write pulse
  output mpc_pkg::mpc_store_s     store_wr_data,          // image to store
  output logic [6:0]              bus_address,            // bus device address
  output logic [9:0]              vout_setting,           // active output level
  output logic [10:0]             output_voltage_ceiling, // ceiling, 10 mV
  output logic                    cfg_ready,              // settings latched
  output logic                    regulate_en,            // run the converter
  output logic                    power_good_output,      // power good
  output logic                    bus_alert_output        // alert, sticky
);

  typedef enum logic [1:0] {ST_SETTLE, ST_LATCH, ST_RUN} mpc_state_e;

  mpc_state_e  state_reg;
  logic [2:0]  settle_cnt_reg;
  logic        first_reg;
  mpc_pin_s    pin_dec [PIN_COUNT];
  logic [9:0]  vout_pins;
  logic [9:0]  thresh_reg;
  logic [9:0]  vout_pin_reg;
  logic [6:0]  addr_next;
  logic [23:0] good_cnt_reg;
  logic        en_meta_reg;
  logic        en_sync_reg;
  logic        band_meta_reg;
  logic        band_sync_reg;
  logic        host_ok;

  // strap kind to table index 0..2
  function automatic logic [3:0] strap_idx(input mpc_kind_e k);
    case (k)
      MPC_KIND_LOW:  strap_idx = 4'h0;
      MPC_KIND_OPEN: strap_idx = 4'h1;
      MPC_KIND_HIGH: strap_idx = 4'h2;
      default:       strap_idx = 4'h0;
    endcase
  endfunction

  // resistor code, strap pins count as code 0 when mixed with a resistor
  function automatic logic [9:0] res_val(input mpc_pin_s p);
    res_val = (p.kind == MPC_KIND_RES) ? {5'h00, p.code} : 10'h000;
  endfunction

  // one classifier per pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      mpc_pin_decode u_dec (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (pin_raw[gi]),
        .pin   (pin_dec[gi])
      );
    end
  endgenerate

  // level inputs from outside pass two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_meta_reg   <= 1'b0;
      en_sync_reg   <= 1'b0;
      band_meta_reg <= 1'b0;
      band_sync_reg <= 1'b0;
    end else begin
      en_meta_reg   <= enable_pin;         // see R12
      en_sync_reg   <= en_meta_reg;
      band_meta_reg <= in_band_pin;
      band_sync_reg <= band_meta_reg;
    end
  end

  // output level from the coarse and fine pins
  always_comb begin
    if (pin_dec[PIN_OUTPUT_LEVEL_FINE].kind == MPC_KIND_RES ||
        pin_dec[PIN_OUTPUT_LEVEL_COARSE].kind == MPC_KIND_RES) begin
      // coarse index times 25 plus fine index
      vout_pins = 10'(res_val(pin_dec[PIN_OUTPUT_LEVEL_COARSE]) * RES_COARSE_STEP)
                + res_val(pin_dec[PIN_OUTPUT_LEVEL_FINE]);                  // see R4
    end else begin
      vout_pins = VOUT_STRAP[4'(strap_idx(pin_dec[PIN_OUTPUT_LEVEL_COARSE].kind) * 4'h3
                           + strap_idx(pin_dec[PIN_OUTPUT_LEVEL_FINE].kind))]; // see R3
    end
  end

  // address: three strap codes, then the 25 resistor codes
  always_comb begin
    if (pin_dec[PIN_BUS_ADDRESS_SELECT].kind == MPC_KIND_RES) begin
      addr_next = ADDR_BASE + ADDR_STRAP_SPAN
                + {2'h0, pin_dec[PIN_BUS_ADDRESS_SELECT].code};            // see R4
    end else begin
      addr_next = ADDR_BASE
                + {3'h0, strap_idx(pin_dec[PIN_BUS_ADDRESS_SELECT].kind)}; // see R3
    end
  end

  assign host_ok = (state_reg == ST_RUN);

  // sampling sequence: power-up and every Restore taken in run resample the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_SETTLE;
      settle_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_SETTLE: begin
          settle_cnt_reg <= settle_cnt_reg + 3'h1;
          if (settle_cnt_reg == 3'(SETTLE_CYCLES - 1)) begin
            state_reg <= ST_LATCH;                                         // see R1
          end
        end
        ST_LATCH: begin
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          settle_cnt_reg <= 3'h0;
          if (restore_cmd) begin
            state_reg <= ST_SETTLE;                                        // see R1
          end
        end
        default: begin
          state_reg <= ST_SETTLE;
        end
      endcase
    end
  end

  // pin-only settings, changed by sampling alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_address            <= ADDR_RESET;
      vout_pin_reg           <= VOUT_RESET;
      output_voltage_ceiling <= 11'h000;
      cfg_ready              <= 1'b0;
    end else begin
      if (state_reg == ST_LATCH) begin
        bus_address            <= addr_next;                               // see R5, R13
        vout_pin_reg           <= vout_pins;
        output_voltage_ceiling <= {1'b0, vout_pins}
                                + {1'b0, vout_pins / 10'h00a};             // see R6
      end
      cfg_ready <= (state_reg == ST_LATCH) || (cfg_ready && state_reg == ST_RUN);
    end
  end

  // host-writable settings: vout loaded at every sampling, thresh only from a stored image at power-up; then only the host moves them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vout_setting <= VOUT_RESET;
      thresh_reg   <= THRESH_RESET;
      first_reg    <= 1'b1;
    end else if (state_reg == ST_LATCH) begin
      first_reg <= 1'b0;
      // a stored image wins at power-up only; Restore reads the pins again
      if (first_reg && store_valid) begin
        vout_setting <= store_rd_data.vout;                                // see R8
        thresh_reg   <= store_rd_data.thresh;
      end else begin
        vout_setting <= vout_pins;                                         // see R13
      end
    end else if (host_ok && host_wr_valid) begin
      // address and ceiling writes are dropped
      if (host_wr_sel == SEL_VOUT) begin
        vout_setting <= host_wr_data;                                      // see R7
      end else if (host_wr_sel == SEL_THRESH) begin
        thresh_reg <= host_wr_data;                                        // see R7, R10
      end
    end
  end

  // read back the values in effect, answer one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rd_data <= 11'h000;
      host_rd_ack  <= 1'b0;
    end else begin
      host_rd_ack <= host_rd_valid;                                        // see R7
      if (host_rd_valid) begin
        case (host_rd_sel)
          SEL_VOUT:   host_rd_data <= {1'b0, vout_setting};
          SEL_THRESH: host_rd_data <= {1'b0, thresh_reg};
          SEL_ADDR:   host_rd_data <= {4'h0, bus_address};
          SEL_CEIL:   host_rd_data <= output_voltage_ceiling;
          default:    host_rd_data <= 11'h000;
        endcase
      end
    end
  end

  // store write is a single pulse carrying the active image
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_wr_en   <= 1'b0;
      store_wr_data <= '0;
    end else begin
      store_wr_en <= host_ok && host_store;                                // see R8
      if (host_ok && host_store) begin
        store_wr_data <= '{vout: vout_setting, thresh: thresh_reg};
      end
    end
  end

  // sticky alert; a measurement above the threshold beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_alert_output <= 1'b0;
    end else if (thresh_reg != 10'h000 && vout_meas > thresh_reg) begin
      bus_alert_output <= 1'b1;                                            // see R10
    end else if (host_alert_clear) begin
      bus_alert_output <= 1'b0;
    end
  end

  // run as soon as settings are latched and enable is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regulate_en <= 1'b0;
    end else begin
      regulate_en <= en_sync_reg && cfg_ready;                             // see R9, R12
    end
  end

  // power good after the band has held for the full delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good_cnt_reg      <= 24'h000000;
      power_good_output <= 1'b0;
    end else if (!(regulate_en && band_sync_reg)) begin
      good_cnt_reg      <= 24'h000000;
      power_good_output <= 1'b0;
    end else if (good_cnt_reg == 24'(GOOD_CYCLES - 1)) begin
      power_good_output <= 1'b1;                                           // see R11
    end else begin
      good_cnt_reg <= good_cnt_reg + 24'h000001;
    end
  end

  a_restore_resample: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    state_reg == ST_RUN && restore_cmd |=> state_reg == ST_SETTLE ##4 state_reg == ST_LATCH)
    else $error("restore did not resample in time");

  a_ceiling_ratio: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    output_voltage_ceiling == {1'b0, vout_pin_reg} + {1'b0, vout_pin_reg / 10'h00a})
    else $error("ceiling not ten percent above pin level");

  a_addr_pins_only: assert property (@(posedge clk) disable iff (!rst_n) // see R5, R13
    state_reg == ST_RUN && !$past(state_reg == ST_LATCH) |-> $stable(bus_address))
    else $error("address moved outside sampling");

  a_host_vout_write: assert property (@(posedge clk) disable iff (!rst_n) // see R7
    host_ok && host_wr_valid && host_wr_sel == SEL_VOUT |=> vout_setting == $past(host_wr_data))
    else $error("host write not taken");

  a_read_answer: assert property (@(posedge clk) disable iff (!rst_n) // see R7
    host_rd_valid && host_rd_sel == SEL_ADDR |=> host_rd_ack && host_rd_data[6:0] == $past(bus_address))
    else $error("read answer wrong");

  a_store_pulse: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    host_ok && host_store |=> store_wr_en && store_wr_data.vout == $past(vout_setting))
    else $error("store write missing");

  a_alert_set_wins: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    thresh_reg != 10'h000 && vout_meas > thresh_reg |=> bus_alert_output)
    else $error("alert not raised");

  a_regulate_gate: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    regulate_en |-> $past(en_sync_reg) && $past(cfg_ready))
    else $error("regulating without enable or settings");

  a_good_needs_band: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    $rose(power_good_output) |-> good_cnt_reg == 24'(GOOD_CYCLES - 1) && $past(band_sync_reg))
    else $error("power good early");

endmodule

// ===== design/mpc_pin_decode.sv
// synchroniser and classifier for one multi-mode pin
`timescale 1ns/100ps
module mpc_pin_decode
  import mpc_pkg::*;
(
  input  wire logic            clk,      // system clock
  input  wire logic            rst_n,    // async reset, active low
  input  wire mpc_pkg::mpc_raw_s raw,    // front-end levels, async
  output mpc_pkg::mpc_pin_s    pin       // classified pin, registered
);

  mpc_raw_s raw_meta_reg;
  mpc_raw_s raw_sync_reg;

  // two flops before anything reads the front end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_meta_reg <= '0;
      raw_sync_reg <= '0;
    end else begin
      raw_meta_reg <= raw;
      raw_sync_reg <= raw_meta_reg;
    end
  end

  // resistor beats levels, since a resistor also pulls the pin low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= '{kind: MPC_KIND_OPEN, code: 5'h00};
    end else if (raw_sync_reg.res_seen) begin
      pin.kind <= MPC_KIND_RES;                           // see R2
      pin.code <= (raw_sync_reg.res_code > RES_CODE_MAX) ?
                  RES_CODE_MAX : raw_sync_reg.res_code;   // see R4
    end else if (raw_sync_reg.lvl_high) begin
      pin <= '{kind: MPC_KIND_HIGH, code: 5'h00};         // see R2
    end else if (raw_sync_reg.lvl_low) begin
      pin <= '{kind: MPC_KIND_LOW, code: 5'h00};          // see R2
    end else begin
      pin <= '{kind: MPC_KIND_OPEN, code: 5'h00};         // see R2
    end
  end

  a_code_in_range: assert property (@(posedge clk) disable iff (!rst_n) // see R4
    pin.code <= RES_CODE_MAX)
    else $error("resistor code above 24");

endmodule

// ===== design/mpc_pkg.sv
// shared constants, types and tables for the multi-mode pin config loader
package mpc_pkg;

  // connection kind of one multi-mode pin
  typedef enum logic [1:0] {
    MPC_KIND_LOW,
    MPC_KIND_OPEN,
    MPC_KIND_HIGH,
    MPC_KIND_RES
  } mpc_kind_e;

  // raw front-end view of one pin, asynchronous to clk
  typedef struct packed {
    logic       lvl_low;   // pin below the low threshold
    logic       lvl_high;  // pin above the high threshold
    logic       res_seen;  // resistor to signal_ground detected
    logic [4:0] res_code;  // resistor index 0..24
  } mpc_raw_s;

  // classified pin
  typedef struct packed {
    mpc_kind_e  kind;
    logic [4:0] code;
  } mpc_pin_s;

  // image held in the persistent_config_store
  typedef struct packed {
    logic [9:0] vout;      // 10 mV units
    logic [9:0] thresh;    // alert threshold, 10 mV units, 0 = off
  } mpc_store_s;

  // pin positions
  localparam int PIN_COUNT                  = 3;
  localparam int PIN_BUS_ADDRESS_SELECT     = 0;
  localparam int PIN_OUTPUT_LEVEL_FINE      = 1;
  localparam int PIN_OUTPUT_LEVEL_COARSE    = 2;

  // resistor decoding
  localparam logic [4:0] RES_CODE_MAX       = 5'h18;  // 25 codes, 0..24
  localparam logic [9:0] RES_COARSE_STEP    = 10'h019; // 25 fine steps per coarse step
  localparam logic [6:0] ADDR_STRAP_SPAN    = 7'h03;  // strap codes before resistor codes

  // host selectors
  localparam logic [1:0] SEL_VOUT           = 2'h0;
  localparam logic [1:0] SEL_THRESH         = 2'h1;
  localparam logic [1:0] SEL_ADDR           = 2'h2;
  localparam logic [1:0] SEL_CEIL           = 2'h3;

  // reset values
  localparam logic [9:0] VOUT_RESET         = 10'h000;
  localparam logic [9:0] THRESH_RESET       = 10'h000;
  localparam logic [6:0] ADDR_RESET         = 7'h00;

  // timing
  localparam int CLK_HZ                     = 100_000_000;
  localparam int SETTLE_CYCLES              = 4;       // covers the two-flop pin sync
  localparam int GOOD_DELAY_MS              = 100;
  localparam int GOOD_DELAY_CYCLES          = (CLK_HZ / 1000) * GOOD_DELAY_MS;

  // strap output level table, coarse major, 10 mV units
  localparam logic [9:0] VOUT_STRAP [9] = '{
    10'h03c, 10'h050, 10'h064,
    10'h078, 10'h096, 10'h0b4,
    10'h0fa, 10'h14a, 10'h1f4
  };

endpackage

// ===== verification/mpc_host_model.sv
// bus host model issuing commands, writes and reads to the loader
`timescale 1ns/100ps
module mpc_host_model (
  input  wire logic        clk,         // system clock
  output logic             restore_cmd, // restore pulse
  output logic             wr_valid,    // write strobe
  output logic [1:0]       wr_sel,      // write selector
  output logic [9:0]       wr_data,     // write value
  output logic             rd_valid,    // read strobe
  output logic [1:0]       rd_sel,      // read selector
  output logic             store,       // store request
  output logic             alert_clear, // alert clear
  input  wire logic [10:0] rd_data,     // read value
  input  wire logic        rd_ack       // read answer
);
  // idle bus at time zero
  initial begin
    {restore_cmd, wr_valid, rd_valid, store, alert_clear} = 5'h00;
    wr_sel = 2'h0;
    wr_data = 10'h000;
    rd_sel = 2'h0;
  end

  // one-cycle write; released data is inverted so stale values never look valid
  task automatic wr(input logic [1:0] s, input logic [9:0] d);
    @(negedge clk);
    wr_sel = s;
    wr_data = d;
    wr_valid = 1'b1;
    @(negedge clk);
    wr_valid = 1'b0;
    wr_data = ~d;
  endtask

  // read; the answer stands for the cycle after the taking edge
  task automatic rd(input logic [1:0] s, output logic [10:0] d, output logic ok);
    @(negedge clk);
    rd_sel = s;
    rd_valid = 1'b1;
    @(negedge clk);
    rd_valid = 1'b0;
    ok = rd_ack;
    d = rd_data;
  endtask

  // one-cycle command pulse: restore, store, alert clear
  task automatic cmd(input logic [2:0] m);
    @(negedge clk);
    {restore_cmd, store, alert_clear} = m;
    @(negedge clk);
    {restore_cmd, store, alert_clear} = 3'h0;
  endtask
endmodule

// ===== verification/mpc_loader_tb.sv
// self-checking bench for the multi-mode pin config loader
`timescale 1ns/100ps
module mpc_loader_tb;
  import mpc_pkg::*;
  localparam int         GOOD  = 20;    // shortened power good delay
  localparam logic [6:0] ABASE = 7'h20; // first bus address
  localparam logic [9:0] RES_V = RES_COARSE_STEP * 10'h005 + 10'h008;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  mpc_raw_s    pins [PIN_COUNT];
  logic        enable_pin = 1'b1;
  logic        store_valid = 1'b0;
  mpc_store_s  store_img = '0;
  logic        in_band_pin = 1'b0;
  logic [9:0]  vout_meas = 10'h3ff;
  logic        restore_cmd, wr_valid, rd_valid, store, alert_clear, rd_ack;
  logic [1:0]  wr_sel, rd_sel;
  logic [9:0]  wr_data, vout_setting;
  logic [10:0] rd_data, ceiling, d;
  logic        store_wr_en, cfg_ready, regulate_en, pg, alert, ok;
  mpc_store_s  store_wr_data;
  logic [6:0]  bus_address;
  int          failures = 0;
  int          cmp_count = 0;

  mpc_loader #(.GOOD_CYCLES(GOOD), .ADDR_BASE(ABASE)) mpc_loader_inst (
    .clk(clk), .rst_n(rst_n), .pin_raw(pins), .enable_pin(enable_pin),
    .in_band_pin(in_band_pin), .restore_cmd(restore_cmd), .host_wr_valid(wr_valid),
    .host_wr_sel(wr_sel), .host_wr_data(wr_data), .host_rd_valid(rd_valid),
    .host_rd_sel(rd_sel), .host_store(store), .host_alert_clear(alert_clear),
    .store_valid(store_valid), .store_rd_data(store_img), .vout_meas(vout_meas),
    .host_rd_data(rd_data), .host_rd_ack(rd_ack), .store_wr_en(store_wr_en),
    .store_wr_data(store_wr_data), .bus_address(bus_address), .vout_setting(vout_setting),
    .output_voltage_ceiling(ceiling), .cfg_ready(cfg_ready), .regulate_en(regulate_en),
    .power_good_output(pg), .bus_alert_output(alert));

  mpc_host_model mpc_host_model_inst (
    .clk(clk), .restore_cmd(restore_cmd), .wr_valid(wr_valid), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_sel(rd_sel), .store(store),
    .alert_clear(alert_clear), .rd_data(rd_data), .rd_ack(rd_ack));

  // raw front-end view of one pin of the given kind
  function automatic mpc_raw_s mk(input mpc_kind_e k, input logic [4:0] c);
    mk = '{k == MPC_KIND_LOW, k == MPC_KIND_HIGH, k == MPC_KIND_RES, c};
  endfunction

  // ceiling is the level plus a tenth, rounded down
  function automatic logic [10:0] ceil_of(input logic [9:0] v);
    ceil_of = 11'(v) + 11'(v / 10);
  endfunction

  task automatic chk_val(input string n, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask

  // bounded wait for settings to be latched
  task automatic wait_ready(input int n);
    for (int i = 0; i < n && cfg_ready !== 1'b1; i++) @(negedge clk);
    chk_bit("cfg_ready", 1'b1, cfg_ready);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic t_powerup;
    wait_ready(12);
    chk_val("bus_address", 11'(ABASE + 7'h02), 11'(bus_address));
    chk_val("vout", 11'(VOUT_STRAP[3]), 11'(vout_setting));
    chk_val("ceiling", ceil_of(VOUT_STRAP[3]), ceiling);
    repeat (4) @(negedge clk);
    chk_bit("regulate_en", 1'b1, regulate_en);
    chk_bit("alert", 1'b0, alert); // zero threshold keeps quiet
    $display("test powerup done");
  endtask

  task automatic t_host;
    mpc_host_model_inst.wr(SEL_VOUT, 10'h0c8);
    chk_val("vout", 11'h0c8, 11'(vout_setting));
    mpc_host_model_inst.rd(SEL_VOUT, d, ok);
    chk_bit("rd_ack", 1'b1, ok);
    chk_val("rd vout", 11'h0c8, d);
    mpc_host_model_inst.wr(SEL_ADDR, 10'h3ff);
    mpc_host_model_inst.wr(SEL_CEIL, 10'h001);
    chk_val("bus_address", 11'(ABASE + 7'h02), 11'(bus_address));
    chk_val("ceiling", ceil_of(VOUT_STRAP[3]), ceiling);
    mpc_host_model_inst.rd(SEL_ADDR, d, ok);
    chk_val("rd addr", 11'(ABASE + 7'h02), d);
    $display("test host done");
  endtask

  task automatic t_store;
    mpc_host_model_inst.cmd(3'b010);
    chk_bit("store_wr_en", 1'b1, store_wr_en);
    chk_val("store vout", 11'h0c8, 11'(store_wr_data.vout));
    @(negedge clk);
    chk_bit("store_wr_en", 1'b0, store_wr_en);
    $display("test store done");
  endtask

  task automatic t_alert;
    vout_meas = 10'h100;
    mpc_host_model_inst.wr(SEL_THRESH, 10'h100);
    @(negedge clk);
    chk_bit("alert", 1'b0, alert); // equal is not above
    vout_meas = 10'h101;
    @(negedge clk);
    chk_bit("alert", 1'b1, alert);
    mpc_host_model_inst.cmd(3'b001);
    chk_bit("alert", 1'b1, alert); // set wins over clear
    vout_meas = 10'h050;
    mpc_host_model_inst.cmd(3'b001);
    chk_bit("alert", 1'b0, alert);
    $display("test alert done");
  endtask

  task automatic t_restore;
    pins[PIN_BUS_ADDRESS_SELECT] = mk(MPC_KIND_RES, 5'h1f);
    pins[PIN_OUTPUT_LEVEL_FINE] = mk(MPC_KIND_RES, 5'h08);
    pins[PIN_OUTPUT_LEVEL_COARSE] = mk(MPC_KIND_RES, 5'h05);
    repeat (6) @(negedge clk);
    chk_val("bus_address", 11'(ABASE + 7'h02), 11'(bus_address));
    mpc_host_model_inst.cmd(3'b100);
    @(negedge clk); // cfg_ready drops one edge after the restore is taken
    chk_bit("cfg_ready", 1'b0, cfg_ready);
    wait_ready(8);
    chk_val("bus_address", 11'(ABASE + 7'h1b), 11'(bus_address)); // code clamps
    chk_val("vout", 11'(RES_V), 11'(vout_setting));
    chk_val("ceiling", ceil_of(RES_V), ceiling);
    $display("test restore done");
  endtask

  task automatic t_good;
    in_band_pin = 1'b1;
    repeat (GOOD) @(negedge clk);
    chk_bit("power_good", 1'b0, pg);
    for (int i = 0; i < 8 && pg !== 1'b1; i++) @(negedge clk);
    chk_bit("power_good", 1'b1, pg);
    in_band_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit("power_good", 1'b0, pg);
    enable_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit("regulate_en", 1'b0, regulate_en);
    $display("test power good done");
  endtask

  // stored image wins at a fresh power-up; address and ceiling stay pin-only
  task automatic t_stored;
    store_valid = 1'b1;
    store_img = '{vout: 10'h0a5, thresh: 10'h2aa};
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit("cfg_ready", 1'b0, cfg_ready);
    rst_n = 1'b1;
    wait_ready(12);
    chk_val("vout", 11'h0a5, 11'(vout_setting));
    mpc_host_model_inst.rd(SEL_THRESH, d, ok);
    chk_val("rd thresh", 11'h2aa, d);
    chk_val("bus_address", 11'(ABASE + 7'h1b), 11'(bus_address));
    chk_val("ceiling", ceil_of(RES_V), ceiling);
    $display("test stored image done");
  endtask

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  // main sequence; pins strapped before reset so they settle ahead of the latch
  initial begin
    pins[PIN_BUS_ADDRESS_SELECT] = mk(MPC_KIND_HIGH, 5'h00);
    pins[PIN_OUTPUT_LEVEL_FINE] = mk(MPC_KIND_LOW, 5'h00);
    pins[PIN_OUTPUT_LEVEL_COARSE] = mk(MPC_KIND_OPEN, 5'h00);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_powerup();
    t_host();
    t_store();
    t_alert();
    t_restore();
    t_good();
    t_stored();
    report_and_stop();
  end

  // watchdog, far beyond the fewer than one hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    $display("FAIL watchdog expected done seen hang");
    report_and_stop();
  end
endmodule
